//--- design/afc_param_bank.sv
`timescale 1ns/1ns
`include "afc_params.svh"

module afc_param_bank
  import afc_pkg::*;
#(
  parameter int unsigned BASE_DELAY_CYC = `AFC_BASE_DELAY_MS * (`AFC_CLK_HZ / 1000),
  parameter int unsigned STEP_DELAY_CYC = `AFC_STEP_DELAY_MS * (`AFC_CLK_HZ / 1000),
  parameter int unsigned SEC_CYC = `AFC_SECOND_S * `AFC_CLK_HZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // decoded register request from the frame engine
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_station,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  // register answer
  output logic rsp_valid,
  output logic rsp_exception,
  output logic [7:0] rsp_exc_code,
  output logic [15:0] rsp_rdata,
  // factory nominal flow
  input wire logic [15:0] nominal_flow,
  // configuration toward the controller
  output logic [15:0] min_flow_pct,
  output logic [15:0] max_flow_pct,
  output logic [15:0] min_flow_units,
  output logic [15:0] max_flow_units,
  output logic [1:0] iface_mode,
  output logic [2:0] flow_unit,
  output logic analog_2to10,
  output logic feedback_position,
  output logic [7:0] station_addr,
  output logic [4:0] serial_code,
  // bus failure fallback
  output logic timeout_active,
  output logic [2:0] fail_action
);

  afc_bank_t st_q;
  afc_bank_t st_d;
  afc_tmr_if tmr_if ();

  // reads: every mapped register, status shows the watchdog
  function automatic logic [15:0] read_value(input afc_bank_t s, input logic [15:0] addr,
                                             input logic fired, input logic [15:0] nom);
    logic [15:0] v;
    v = 16'h0000;
    unique case (addr)
      `AFC_REG_STATUS: v[`AFC_STATUS_TIMEOUT_BIT] = fired;
      `AFC_REG_MIN_PCT: v = s.min_pct;
      `AFC_REG_MAX_PCT: v = s.max_pct;
      `AFC_REG_FAIL_ACT: v = s.fail_act;
      `AFC_REG_TO_SECS: v = s.to_secs;
      `AFC_REG_MIN_UNITS: v = s.min_units;
      `AFC_REG_MAX_UNITS: v = s.max_units;
      `AFC_REG_IFACE_MODE: v = s.iface_mode;
      `AFC_REG_STATION: v = s.station;
      `AFC_REG_FLOW_UNIT: v = s.flow_unit;
      `AFC_REG_MODE_BITS: v = s.mode_bits;
      `AFC_REG_NOM_FLOW: v = nom;
      `AFC_REG_SERIAL: v = s.serial;
      `AFC_REG_RSP_DELAY: v = s.rsp_delay;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : read_value

  function automatic logic is_mapped(input logic [15:0] addr);
    logic m;
    m = 1'b0;
    unique case (addr)
      `AFC_REG_STATUS, `AFC_REG_MIN_PCT, `AFC_REG_MAX_PCT, `AFC_REG_FAIL_ACT,
      `AFC_REG_TO_SECS, `AFC_REG_MIN_UNITS, `AFC_REG_MAX_UNITS, `AFC_REG_IFACE_MODE,
      `AFC_REG_STATION, `AFC_REG_FLOW_UNIT, `AFC_REG_MODE_BITS, `AFC_REG_NOM_FLOW,
      `AFC_REG_SERIAL, `AFC_REG_RSP_DELAY: m = 1'b1;
      default: m = 1'b0;
    endcase
    return m;
  endfunction : is_mapped

  // write check: read-only or unmapped is an address fault, bad code a value fault
  function automatic logic [7:0] write_check(input logic [15:0] addr, input logic [15:0] val);
    logic [7:0] e;
    e = `AFC_EXC_NONE;
    unique case (addr)
      `AFC_REG_STATUS, `AFC_REG_NOM_FLOW: e = `AFC_EXC_ADDR;
      `AFC_REG_MIN_PCT, `AFC_REG_MAX_PCT: begin
        if (val > `AFC_PCT_MAX) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_FAIL_ACT: begin
        if (!(val == {13'h0000, `AFC_ACT_NONE} || val == {13'h0000, `AFC_ACT_CLOSE} ||
              val == {13'h0000, `AFC_ACT_OPEN} || val == {13'h0000, `AFC_ACT_QVMIN} ||
              val == {13'h0000, `AFC_ACT_QVMAX})) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_IFACE_MODE: begin
        if (val > `AFC_IFM_MAX) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_STATION: begin
        if (val < `AFC_ADDR_MIN || val > `AFC_ADDR_MAX) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_FLOW_UNIT: begin
        if (!(val == `AFC_UNIT_LPS || val == `AFC_UNIT_M3H || val == `AFC_UNIT_CFM)) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_SERIAL: begin
        if (val > `AFC_SER_MAX) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_RSP_DELAY: begin
        if (val > `AFC_DLY_MAX) begin
          e = `AFC_EXC_VALUE;
        end
      end
      `AFC_REG_TO_SECS, `AFC_REG_MIN_UNITS, `AFC_REG_MAX_UNITS, `AFC_REG_MODE_BITS: begin
        e = `AFC_EXC_NONE;
      end
      default: e = `AFC_EXC_ADDR;
    endcase
    return e;
  endfunction : write_check

  always_comb begin
    logic ours;
    logic bcast;
    logic [7:0] exc;
    ours = 1'b0;
    bcast = 1'b0;
    exc = `AFC_EXC_NONE;
    st_d = st_q;
    st_d.rsp_valid = 1'b0;
    st_d.tmr_start = 1'b0;
    st_d.tmr_kick = 1'b0;
    // fallback action only while the watchdog has fired
    st_d.timed_out = tmr_if.to_fired;
    st_d.override_act = tmr_if.to_fired ? st_q.fail_act[2:0] : `AFC_ACT_NONE;
    unique case (st_q.phase)
      AFC_IDLE: begin
        if (req_valid) begin
          ours = (req_station == st_q.station[7:0]);
          bcast = (req_station == `AFC_BROADCAST) && req_write;
          if (req_write) begin
            exc = write_check(req_addr, req_wdata);
          end else if (!is_mapped(req_addr)) begin
            exc = `AFC_EXC_ADDR;
          end
          if (ours || bcast) begin
            st_d.tmr_kick = 1'b1;
            // a rejected write leaves the stored value as it was
            if (req_write && exc == `AFC_EXC_NONE) begin
              unique case (req_addr)
                `AFC_REG_MIN_PCT: st_d.min_pct = req_wdata;
                `AFC_REG_MAX_PCT: st_d.max_pct = req_wdata;
                `AFC_REG_FAIL_ACT: st_d.fail_act = req_wdata;
                `AFC_REG_TO_SECS: st_d.to_secs = req_wdata;
                `AFC_REG_MIN_UNITS: st_d.min_units = req_wdata;
                `AFC_REG_MAX_UNITS: st_d.max_units = req_wdata;
                `AFC_REG_IFACE_MODE: st_d.iface_mode = req_wdata;
                `AFC_REG_STATION: st_d.station = req_wdata;
                `AFC_REG_FLOW_UNIT: st_d.flow_unit = req_wdata;
                // all 16 bits stored; the master keeps the rest intact
                `AFC_REG_MODE_BITS: st_d.mode_bits = req_wdata;
                `AFC_REG_SERIAL: st_d.serial = req_wdata;
                `AFC_REG_RSP_DELAY: st_d.rsp_delay = req_wdata;
                default: st_d.min_pct = st_q.min_pct;
              endcase
            end
          end
          // broadcast writes execute silently, only own address gets an answer
          if (ours) begin
            st_d.phase = AFC_WAIT;
            st_d.req_ready = 1'b0;
            st_d.tmr_start = 1'b1;
            st_d.rsp_exc = (exc != `AFC_EXC_NONE);
            st_d.rsp_code = exc;
            st_d.rsp_data = (exc != `AFC_EXC_NONE) ? 16'h0000 :
                            req_write ? req_wdata :
                            read_value(st_q, req_addr, tmr_if.to_fired, nominal_flow);
          end
        end
      end
      AFC_WAIT: begin
        if (tmr_if.rsp_done) begin
          st_d.phase = AFC_IDLE;
          st_d.req_ready = 1'b1;
          st_d.rsp_valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.phase <= AFC_IDLE;
      st_q.req_ready <= 1'b1;
      st_q.min_pct <= `AFC_RST_MIN_PCT;
      st_q.max_pct <= `AFC_RST_MAX_PCT;
      st_q.fail_act <= `AFC_RST_FAIL_ACT;
      st_q.to_secs <= `AFC_RST_TO_SECS;
      st_q.min_units <= `AFC_RST_MIN_UNITS;
      st_q.max_units <= `AFC_RST_MAX_UNITS;
      st_q.iface_mode <= `AFC_RST_IFACE_MODE;
      st_q.station <= `AFC_RST_STATION;
      st_q.flow_unit <= `AFC_RST_FLOW_UNIT;
      st_q.mode_bits <= `AFC_RST_MODE_BITS;
      st_q.serial <= `AFC_RST_SERIAL;
      st_q.rsp_delay <= `AFC_RST_RSP_DELAY;
    end else begin
      st_q <= st_d;
    end
  end

  assign tmr_if.rsp_start = st_q.tmr_start;
  assign tmr_if.rsp_extra = st_q.rsp_delay[7:0];
  assign tmr_if.kick = st_q.tmr_kick;
  assign tmr_if.to_secs = st_q.to_secs;

  afc_timer #(
    .BASE_DELAY_CYC(BASE_DELAY_CYC),
    .STEP_DELAY_CYC(STEP_DELAY_CYC),
    .SEC_CYC(SEC_CYC)
  ) u_timer (
    .clock(clock),
    .reset(reset),
    .tmr(tmr_if.timer)
  );

  assign req_ready = st_q.req_ready;
  assign rsp_valid = st_q.rsp_valid;
  assign rsp_exception = st_q.rsp_exc;
  assign rsp_exc_code = st_q.rsp_code;
  assign rsp_rdata = st_q.rsp_data;
  assign min_flow_pct = st_q.min_pct;
  assign max_flow_pct = st_q.max_pct;
  assign min_flow_units = st_q.min_units;
  assign max_flow_units = st_q.max_units;
  assign iface_mode = st_q.iface_mode[1:0];
  assign flow_unit = st_q.flow_unit[2:0];
  assign analog_2to10 = st_q.mode_bits[`AFC_MODE_CHAR_BIT];
  assign feedback_position = st_q.mode_bits[`AFC_MODE_FB_BIT];
  assign station_addr = st_q.station[7:0];
  assign serial_code = st_q.serial[4:0];
  assign timeout_active = st_q.timed_out;
  assign fail_action = st_q.override_act;

endmodule : afc_param_bank

//--- design/afc_params.svh
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH

// register offsets (holding-register numbers)
`define AFC_REG_STATUS 16'h0068
`define AFC_REG_MIN_PCT 16'h0069
`define AFC_REG_MAX_PCT 16'h006a
`define AFC_REG_FAIL_ACT 16'h006c
`define AFC_REG_TO_SECS 16'h006d
`define AFC_REG_MIN_UNITS 16'h0078
`define AFC_REG_MAX_UNITS 16'h0079
`define AFC_REG_IFACE_MODE 16'h007a
`define AFC_REG_STATION 16'h0082
`define AFC_REG_FLOW_UNIT 16'h00c9
`define AFC_REG_MODE_BITS 16'h00e7
`define AFC_REG_NOM_FLOW 16'h00e9
`define AFC_REG_SERIAL 16'h0238
`define AFC_REG_RSP_DELAY 16'h0239

// field positions
`define AFC_STATUS_TIMEOUT_BIT 10
`define AFC_MODE_CHAR_BIT 0
`define AFC_MODE_FB_BIT 4

// legal value ranges and codes
`define AFC_PCT_MAX 16'h2710
`define AFC_ACT_NONE 3'h0
`define AFC_ACT_CLOSE 3'h1
`define AFC_ACT_OPEN 3'h2
`define AFC_ACT_QVMIN 3'h3
`define AFC_ACT_QVMAX 3'h5
`define AFC_UNIT_LPS 16'h0000
`define AFC_UNIT_M3H 16'h0001
`define AFC_UNIT_CFM 16'h0006
`define AFC_IFM_MAX 16'h0003
`define AFC_SER_MAX 16'h001f
`define AFC_DLY_MAX 16'h00ff
`define AFC_ADDR_MIN 16'h0001
`define AFC_ADDR_MAX 16'h00f7
`define AFC_BROADCAST 8'h00

// exception codes
`define AFC_EXC_NONE 8'h00
`define AFC_EXC_ADDR 8'h02
`define AFC_EXC_VALUE 8'h03

// reset values
`define AFC_RST_MIN_PCT 16'h0000
`define AFC_RST_MAX_PCT 16'h2710
`define AFC_RST_FAIL_ACT 16'h0000
`define AFC_RST_TO_SECS 16'h0000
`define AFC_RST_MIN_UNITS 16'h0000
`define AFC_RST_MAX_UNITS 16'h0000
`define AFC_RST_IFACE_MODE 16'h0001
`define AFC_RST_STATION 16'h0001
`define AFC_RST_FLOW_UNIT 16'h0001
`define AFC_RST_MODE_BITS 16'h0000
`define AFC_RST_SERIAL 16'h000f
`define AFC_RST_RSP_DELAY 16'h0000

// timing
`define AFC_CLK_HZ 100000000
`define AFC_BASE_DELAY_MS 10
`define AFC_STEP_DELAY_MS 3
`define AFC_SECOND_S 1

`endif

//--- design/afc_pkg.sv
package afc_pkg;

  typedef enum logic [0:0] {
    AFC_IDLE,
    AFC_WAIT
  } afc_phase_t;

  typedef struct packed {
    afc_phase_t phase;
    logic req_ready;
    logic rsp_valid;
    logic rsp_exc;
    logic [7:0] rsp_code;
    logic [15:0] rsp_data;
    logic tmr_start;
    logic tmr_kick;
    logic timed_out;
    logic [2:0] override_act;
    logic [15:0] min_pct;
    logic [15:0] max_pct;
    logic [15:0] fail_act;
    logic [15:0] to_secs;
    logic [15:0] min_units;
    logic [15:0] max_units;
    logic [15:0] iface_mode;
    logic [15:0] station;
    logic [15:0] flow_unit;
    logic [15:0] mode_bits;
    logic [15:0] serial;
    logic [15:0] rsp_delay;
  } afc_bank_t;

  typedef struct packed {
    logic rsp_busy;
    logic rsp_done;
    logic [31:0] rsp_cnt;
    logic armed;
    logic fired;
    logic [31:0] sec_cnt;
    logic [15:0] secs_left;
  } afc_tmr_t;

endpackage : afc_pkg

//--- design/afc_tmr_if.sv
`timescale 1ns/1ns
interface afc_tmr_if;
  logic rsp_start;
  logic [7:0] rsp_extra;
  logic rsp_done;
  logic kick;
  logic [15:0] to_secs;
  logic to_fired;

  modport bank (
    output rsp_start,
    output rsp_extra,
    output kick,
    output to_secs,
    input rsp_done,
    input to_fired
  );

  modport timer (
    input rsp_start,
    input rsp_extra,
    input kick,
    input to_secs,
    output rsp_done,
    output to_fired
  );
endinterface : afc_tmr_if

//--- design/afc_timer.sv
`timescale 1ns/1ns
module afc_timer
  import afc_pkg::*;
#(
  parameter int unsigned BASE_DELAY_CYC = 1000000,
  parameter int unsigned STEP_DELAY_CYC = 300000,
  parameter int unsigned SEC_CYC = 100000000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // link to the register bank
  afc_tmr_if.timer tmr
);

  afc_tmr_t st_q;
  afc_tmr_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.rsp_done = 1'b0;
    // response wait: base plus per-step extra, counted down to zero
    if (tmr.rsp_start) begin
      st_d.rsp_busy = 1'b1;
      st_d.rsp_cnt = 32'(BASE_DELAY_CYC) + 32'(STEP_DELAY_CYC) * {24'h000000, tmr.rsp_extra}
                     - 32'h00000001;
    end else if (st_q.rsp_busy) begin
      if (st_q.rsp_cnt == 32'h00000000) begin
        st_d.rsp_busy = 1'b0;
        st_d.rsp_done = 1'b1;
      end else begin
        st_d.rsp_cnt = st_q.rsp_cnt - 32'h00000001;
      end
    end
    // bus silence watchdog in whole seconds; zero disables it
    if (tmr.to_secs == 16'h0000) begin
      st_d.armed = 1'b0;
      st_d.fired = 1'b0;
    end else if (tmr.kick) begin
      st_d.armed = 1'b1;
      st_d.fired = 1'b0;
      st_d.secs_left = tmr.to_secs;
      st_d.sec_cnt = 32'(SEC_CYC) - 32'h00000001;
    end else if (st_q.armed && !st_q.fired) begin
      if (st_q.sec_cnt == 32'h00000000) begin
        st_d.sec_cnt = 32'(SEC_CYC) - 32'h00000001;
        if (st_q.secs_left <= 16'h0001) begin
          st_d.fired = 1'b1;
          st_d.secs_left = 16'h0000;
        end else begin
          st_d.secs_left = st_q.secs_left - 16'h0001;
        end
      end else begin
        st_d.sec_cnt = st_q.sec_cnt - 32'h00000001;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tmr.rsp_done = st_q.rsp_done;
  assign tmr.to_fired = st_q.fired;

endmodule : afc_timer

//--- tb/afc_bank_chk.sv
`timescale 1ns/1ns
module afc_bank_chk #(
  parameter int unsigned BASE_DELAY_CYC = 10,
  parameter int unsigned STEP_DELAY_CYC = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // request and answer
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_station,
  input wire logic [15:0] req_addr,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_exc_code,
  input wire logic [15:0] rsp_rdata,
  // configuration
  input wire logic [15:0] min_flow_pct,
  input wire logic [15:0] max_flow_pct,
  input wire logic [2:0] flow_unit,
  input wire logic [7:0] station_addr,
  input wire logic timeout_active,
  input wire logic [2:0] fail_action
);
  localparam int LAT_LO = BASE_DELAY_CYC + 3;
  localparam int LAT_HI = BASE_DELAY_CYC + STEP_DELAY_CYC * 255 + 3;
  // age of the open own-station request, 0 when none is open
  logic [15:0] age_q;
  logic take_own;
  assign take_own = req_valid && req_ready && req_station == station_addr;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) age_q <= 16'h0;
    else if (take_own) age_q <= 16'h1;
    else if (rsp_valid) age_q <= 16'h0;
    else if (age_q != 16'h0) age_q <= age_q + 16'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_take_own;
    take_own;
  endsequence
  sequence s_ro_write;
    s_take_own ##0 (req_write && req_addr == 16'he9);
  endsequence
  a_take_holds_off: assert property (s_take_own |=> !req_ready && !rsp_valid)
    else $error("ready or valid high right after a take");
  a_ro_refused: assert property (s_ro_write |=> rsp_exception && rsp_exc_code == 8'h02)
    else $error("write to read-only nominal flow not refused");
  a_valid_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  a_ready_returns: assert property ($rose(rsp_valid) |-> req_ready)
    else $error("ready not back with the answer");
  a_answer_delay: assert property (rsp_valid |-> age_q >= LAT_LO && age_q <= LAT_HI)
    else $error("answer outside base plus step delay");
  a_own_station: assert property ((req_valid && req_ready && req_station != station_addr
    && req_station != 8'h00) |=> req_ready && !rsp_valid)
    else $error("foreign station request was taken");
  a_exc_clean: assert property (rsp_valid |-> (rsp_exception ?
    (rsp_exc_code inside {8'h02, 8'h03} && rsp_rdata == 16'h0) : rsp_exc_code == 8'h00))
    else $error("exception code or data inconsistent");
  a_fail_gated: assert property (!timeout_active |-> fail_action == 3'h0)
    else $error("fail action without timeout");
  a_codes_legal: assert property (flow_unit inside {3'h0, 3'h1, 3'h6}
    && min_flow_pct <= 16'h2710 && max_flow_pct <= 16'h2710)
    else $error("unit code or limit out of range");
  a_fail_legal: assert property (fail_action inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5})
    else $error("undefined fail action");
endmodule : afc_bank_chk

bind afc_param_bank afc_bank_chk #(
  .BASE_DELAY_CYC(BASE_DELAY_CYC),
  .STEP_DELAY_CYC(STEP_DELAY_CYC)
) u_chk (
  .clock, .reset, .req_valid, .req_write, .req_station, .req_addr, .req_ready, .rsp_valid,
  .rsp_exception, .rsp_exc_code, .rsp_rdata, .min_flow_pct, .max_flow_pct, .flow_unit,
  .station_addr, .timeout_active, .fail_action
);

//--- tb/afc_master_model.sv
`timescale 1ns/1ns
module afc_master_model (
  // clock
  input wire logic clock,
  // request side
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_station,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  // answer side
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_exc_code,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    req_valid = 1'b0;
    {req_write, req_station, req_addr, req_wdata} = '0;
  end
  // called at a falling edge; configuration writes are one-shot, never cyclic
  task automatic xfer(input logic wr, input logic [7:0] st, input logic [15:0] ad,
      input logic [15:0] wd, output logic got, output logic [7:0] code,
      output logic [15:0] rd, output int lat);
    int n;
    got = 1'b0;
    code = 8'hff;
    rd = 16'h0;
    for (n = 0; n < 2000 && req_ready !== 1'b1; n++) @(negedge clock);
    // ready never came back: report with lat at zero, send nothing
    if (req_ready !== 1'b1) begin
      lat = 0;
      return;
    end
    req_valid = 1'b1;
    {req_write, req_station, req_addr, req_wdata} = {wr, st, ad, wd};
    @(negedge clock);
    // released lines must not keep showing the old request
    req_valid = 1'b0;
    {req_write, req_station, req_addr, req_wdata} = ~{wr, st, ad, wd};
    for (lat = 1; lat <= 800; lat++) begin
      @(negedge clock);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        code = rsp_exception ? rsp_exc_code : 8'h00;
        rd = rsp_rdata;
        break;
      end
    end
  endtask : xfer
endmodule : afc_master_model

//--- tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int BASE = 10;
  localparam int STEP = 3;
  logic clock, reset, req_valid, req_write, req_ready, rsp_valid, rsp_exception;
  logic [7:0] req_station, rsp_exc_code, station_addr, code;
  logic [15:0] req_addr, req_wdata, rsp_rdata, nominal_flow, rd;
  logic [15:0] min_flow_pct, max_flow_pct, min_flow_units, max_flow_units;
  logic [1:0] iface_mode;
  logic [2:0] flow_unit, fail_action;
  logic [4:0] serial_code;
  logic analog_2to10, feedback_position, timeout_active, got;
  int lat, dly, mismatches, checks_done;

  always #5 clock = ~clock;

  afc_param_bank #(.BASE_DELAY_CYC(BASE), .STEP_DELAY_CYC(STEP), .SEC_CYC(20)) dut (
    .clock, .reset, .req_valid, .req_write, .req_station, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_exception, .rsp_exc_code, .rsp_rdata, .nominal_flow, .min_flow_pct,
    .max_flow_pct, .min_flow_units, .max_flow_units, .iface_mode, .flow_unit, .analog_2to10,
    .feedback_position, .station_addr, .serial_code, .timeout_active, .fail_action
  );
  afc_master_model master (
    .clock, .req_valid, .req_write, .req_station, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_exception, .rsp_exc_code, .rsp_rdata
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one transfer; ans low means the block must stay silent
  task automatic acc(input logic wr, input logic [7:0] st, input logic [15:0] ad,
      input logic [15:0] wd, input logic ans, input logic [7:0] ec, input logic [15:0] er);
    master.xfer(wr, st, ad, wd, got, code, rd, lat);
    if (lat == 0) begin
      check("ready wait", 1'b0, 1'b1);
      results();
    end
    check("answered", got, ans);
    if (ans && got !== 1'b1) results();
    if (ans) begin
      check("exc code", code, ec);
      check("data", rd, er);
      check("latency", lat, BASE + STEP * dly + 2);
    end
  endtask : acc

  task automatic t_reset;
    check("station", station_addr, 8'h01);
    check("max pct", max_flow_pct, 16'h2710);
    check("iface", iface_mode, 2'h1);
    check("serial", serial_code, 5'h0f);
    check("timeout", timeout_active, 1'b0);
    acc(0, 1, 16'he9, 0, 1, 0, 16'h0123);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    // address, legal value, illegal value (same as legal when every value is legal)
    logic [47:0] tab [19] = '{48'h0069_2710_2711, 48'h006a_0000_ffff, 48'h006c_0000_0004,
      48'h006c_0001_0006, 48'h006c_0002_0007, 48'h006c_0003_0004, 48'h006c_0005_0008,
      48'h006d_0007_0007, 48'h0078_1234_1234, 48'h0079_abcd_abcd, 48'h007a_0000_0004,
      48'h007a_0002_ffff, 48'h007a_0003_0005, 48'h007a_0001_0004, 48'h00c9_0000_0002,
      48'h00c9_0006_0007, 48'h00c9_0001_0003, 48'h0238_001f_0020, 48'h0238_000f_0100};
    for (int i = 0; i < 19; i++) begin
      acc(1, 1, tab[i][47:32], tab[i][31:16], 1, 0, tab[i][31:16]);
      if (tab[i][15:0] != tab[i][31:16]) begin
        acc(1, 1, tab[i][47:32], tab[i][15:0], 1, 8'h03, 0);
      end
      acc(0, 1, tab[i][47:32], 0, 1, 0, tab[i][31:16]);
    end
    check("max pct", max_flow_pct, 16'h0);
    check("min units", min_flow_units, 16'h1234);
    check("max units", max_flow_units, 16'habcd);
    check("unit", flow_unit, 3'h1);
    check("serial", serial_code, 5'h0f);
    acc(1, 1, 16'he9, 16'h5555, 1, 8'h02, 0);
    acc(0, 1, 16'he9, 0, 1, 0, 16'h0123);
    acc(0, 1, 16'h6b, 0, 1, 8'h02, 0);
    acc(1, 1, 16'h6b, 16'h1, 1, 8'h02, 0);
    acc(1, 1, 16'h68, 16'h0400, 1, 8'h02, 0);
    acc(0, 1, 16'h68, 0, 1, 0, 0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_mode;
    acc(0, 1, 16'he7, 0, 1, 0, 0);
    acc(1, 1, 16'he7, rd | 16'h1, 1, 0, 16'h1);
    check("2-10 V", analog_2to10, 1'b1);
    acc(1, 1, 16'he7, rd | 16'h10, 1, 0, 16'h11);
    check("position", feedback_position, 1'b1);
    acc(1, 1, 16'he7, rd & ~16'h1, 1, 0, 16'h10);
    check("0-10 V", analog_2to10, 1'b0);
    $display("test mode done");
  endtask : t_mode

  task automatic t_station;
    acc(0, 8'h05, 16'h82, 0, 0, 0, 0);
    acc(1, 1, 16'h82, 16'h22, 1, 0, 16'h22);
    check("station", station_addr, 8'h22);
    acc(0, 1, 16'h82, 0, 0, 0, 0);
    acc(1, 8'h22, 16'h82, 16'h0, 1, 8'h03, 0);
    acc(1, 8'h00, 16'h69, 16'h100, 0, 0, 0);
    check("min pct", min_flow_pct, 16'h0100);
    acc(0, 8'h00, 16'h82, 0, 0, 0, 0);
    acc(0, 8'h22, 16'h69, 0, 1, 0, 16'h100);
    acc(1, 8'h22, 16'h82, 16'h1, 1, 0, 16'h1);
    $display("test station done");
  endtask : t_station

  task automatic t_watch;
    int k;
    acc(1, 1, 16'h6d, 16'h1, 1, 0, 16'h1);
    acc(0, 1, 16'h6d, 0, 1, 0, 16'h1);
    for (k = 0; k < 100 && timeout_active !== 1'b1; k++) @(negedge clock);
    check("fired", timeout_active, 1'b1);
    if (k == 100) results();
    check("action", fail_action, 3'h5);
    acc(0, 1, 16'h68, 0, 1, 0, 16'h0400);
    check("cleared", timeout_active, 1'b0);
    acc(1, 1, 16'h6d, 0, 1, 0, 0);
    $display("test watchdog done");
  endtask : t_watch

  task automatic t_delay;
    dly = 2;
    acc(1, 1, 16'h239, 16'h2, 1, 0, 16'h2);
    acc(0, 1, 16'h239, 0, 1, 0, 16'h2);
    dly = 255;
    acc(1, 1, 16'h239, 16'hff, 1, 0, 16'hff);
    acc(1, 1, 16'h239, 16'h100, 1, 8'h03, 0);
    dly = 0;
    acc(1, 1, 16'h239, 0, 1, 0, 0);
    $display("test delay done");
  endtask : t_delay

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    nominal_flow = 16'h0123;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_regs();
    t_mode();
    t_station();
    t_watch();
    t_delay();
    results();
  end
endmodule : testbench
